// ---- rair_top.sv ----
/*
 Alarm compare and routing of the two clock requests into fast interrupt inputs 2 and 3.
 Assumes the time counters, second tick and alarm enable come from logic on REF_CLK;
 the fast interrupt pins come from outside and are synchronised here.
*/
`timescale 1ns/1ns
module rair_top
   import rair_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic [15:0] CNT_HIGH,
   input wire logic [15:0] CNT_LOW,
   input wire logic ALARM_IRQ_ENABLE_BIT,
   input wire logic SECOND_TICK_IN,
   input wire logic [1:0] FIRQ_PIN,
   input wire logic [15:0] ADDR,
   input wire logic WR_EN,
   input wire logic [15:0] WDATA,
   input wire logic RD_EN,
   output logic [15:0] RDATA,
   output logic SECOND_TICK_REQUEST_LINE,
   output logic ALARM_REQUEST_LINE,
   output logic SECOND_TICK_IRQ,
   output logic ALARM_IRQ
);
   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [15:0] alarm_match_low;
      logic [15:0] alarm_match_high;
      logic [15:0] ext_irq_edge_select;
      logic [15:0] ext_irq_source_select;
      logic [7:0] second_tick_irq_control;
      logic [7:0] alarm_irq_control;
      logic [1:0] pin_meta;
      logic [1:0] pin_sync;
      logic second_line;
      logic alarm_line;
      logic [15:0] rdata;
      logic sec_irq;
      logic alm_irq;
   } rair_top_state_t;

   rair_top_state_t st_ff;
   rair_top_state_t nxt_st;
   logic [31:0] time_value;
   logic alarm_match;
   logic sec_event;
   logic alm_event;

   assign time_value = {CNT_HIGH, CNT_LOW};
   assign alarm_match = time_value == {st_ff.alarm_match_high, st_ff.alarm_match_low};

   // ************************************************************
   // Fast interrupt inputs 2 and 3
   // ************************************************************
   rair_fast_input u_sec_input (
      .clk(REF_CLK),
      .rst(RST),
      .pin(st_ff.pin_sync[0]),
      .alt(st_ff.second_line),
      .edge_code(st_ff.ext_irq_edge_select[RAIR_SEC_LSB +: RAIR_FIELD_W]),
      .src_code(st_ff.ext_irq_source_select[RAIR_SEC_LSB +: RAIR_FIELD_W]),
      .event_pulse(sec_event)
   );

   rair_fast_input u_alm_input (
      .clk(REF_CLK),
      .rst(RST),
      .pin(st_ff.pin_sync[1]),
      .alt(st_ff.alarm_line),
      .edge_code(st_ff.ext_irq_edge_select[RAIR_ALM_LSB +: RAIR_FIELD_W]),
      .src_code(st_ff.ext_irq_source_select[RAIR_ALM_LSB +: RAIR_FIELD_W]),
      .event_pulse(alm_event)
   );

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      nxt_st = st_ff;
      nxt_st.pin_meta = FIRQ_PIN;
      nxt_st.pin_sync = st_ff.pin_meta;
      nxt_st.second_line = SECOND_TICK_IN;
      // Level follows the match gated by the enable, so one rise per match
      nxt_st.alarm_line = alarm_match & ALARM_IRQ_ENABLE_BIT;

      if (WR_EN) begin
         case (ADDR)
            RAIR_ADDR_ALARM_LOW: nxt_st.alarm_match_low = WDATA;
            RAIR_ADDR_ALARM_HIGH: nxt_st.alarm_match_high = WDATA;
            RAIR_ADDR_EDGE_SEL: nxt_st.ext_irq_edge_select = WDATA;
            RAIR_ADDR_SRC_SEL: nxt_st.ext_irq_source_select = WDATA;
            RAIR_ADDR_SEC_IC: nxt_st.second_tick_irq_control = WDATA[7:0];
            RAIR_ADDR_ALM_IC: nxt_st.alarm_irq_control = WDATA[7:0];
            default: nxt_st.rdata = st_ff.rdata;
         endcase
      end

      // Hardware set wins over a software clear
      if (sec_event) begin
         nxt_st.second_tick_irq_control[RAIR_IR_BIT] = 1'b1;
      end
      if (alm_event) begin
         nxt_st.alarm_irq_control[RAIR_IR_BIT] = 1'b1;
      end
      nxt_st.sec_irq = nxt_st.second_tick_irq_control[RAIR_IR_BIT]
                       & nxt_st.second_tick_irq_control[RAIR_IE_BIT];
      nxt_st.alm_irq = nxt_st.alarm_irq_control[RAIR_IR_BIT] & nxt_st.alarm_irq_control[RAIR_IE_BIT];

      if (RD_EN) begin
         case (ADDR)
            RAIR_ADDR_ALARM_LOW: nxt_st.rdata = st_ff.alarm_match_low;
            RAIR_ADDR_ALARM_HIGH: nxt_st.rdata = st_ff.alarm_match_high;
            RAIR_ADDR_EDGE_SEL: nxt_st.rdata = st_ff.ext_irq_edge_select;
            RAIR_ADDR_SRC_SEL: nxt_st.rdata = st_ff.ext_irq_source_select;
            RAIR_ADDR_SEC_IC: nxt_st.rdata = {8'h00, st_ff.second_tick_irq_control};
            RAIR_ADDR_ALM_IC: nxt_st.rdata = {8'h00, st_ff.alarm_irq_control};
            default: nxt_st.rdata = RAIR_READ_NONE;
         endcase
      end

      // Reset spares the alarm value
      if (RST) begin
         nxt_st.ext_irq_edge_select = RAIR_EDGE_SEL_RESET;
         nxt_st.ext_irq_source_select = RAIR_SRC_SEL_RESET;
         nxt_st.second_tick_irq_control = RAIR_IC_RESET;
         nxt_st.alarm_irq_control = RAIR_IC_RESET;
         nxt_st.pin_meta = 2'h0;
         nxt_st.pin_sync = 2'h0;
         nxt_st.second_line = 1'b0;
         nxt_st.alarm_line = 1'b0;
         nxt_st.rdata = RAIR_READ_NONE;
         nxt_st.sec_irq = 1'b0;
         nxt_st.alm_irq = 1'b0;
         nxt_st.alarm_match_low = st_ff.alarm_match_low;
         nxt_st.alarm_match_high = st_ff.alarm_match_high;
      end
   end

   always_ff @(posedge REF_CLK) begin
      st_ff <= nxt_st;
   end

   assign RDATA = st_ff.rdata;
   assign SECOND_TICK_REQUEST_LINE = st_ff.second_line;
   assign ALARM_REQUEST_LINE = st_ff.alarm_line;
   assign SECOND_TICK_IRQ = st_ff.sec_irq;
   assign ALARM_IRQ = st_ff.alm_irq;
endmodule

// ---- rair_pkg.sv ----
/*
 Constants and types for the alarm compare and interrupt routing block.
 Assumes a 16-bit register port clocked with the block and byte-addressed offsets.
*/
package rair_pkg;
   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [15:0] RAIR_ADDR_ALARM_LOW = 16'hEC12;
   localparam logic [15:0] RAIR_ADDR_ALARM_HIGH = 16'hEC14;
   localparam logic [15:0] RAIR_ADDR_EDGE_SEL = 16'hF1C0;
   localparam logic [15:0] RAIR_ADDR_SRC_SEL = 16'hF1DA;
   localparam logic [15:0] RAIR_ADDR_SEC_IC = 16'hFF8C;
   localparam logic [15:0] RAIR_ADDR_ALM_IC = 16'hFF8E;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [15:0] RAIR_EDGE_SEL_RESET = 16'h0000;
   localparam logic [15:0] RAIR_SRC_SEL_RESET = 16'h0000;
   localparam logic [7:0] RAIR_IC_RESET = 8'h00;
   localparam logic [15:0] RAIR_READ_NONE = 16'h0000;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int RAIR_IR_BIT = 7;
   localparam int RAIR_IE_BIT = 6;
   localparam int RAIR_PRIORITY_LEVEL_FIELD_LSB = 2;
   localparam int RAIR_GROUP_LEVEL_FIELD_LSB = 0;
   localparam int RAIR_FIELD_W = 2;
   localparam int RAIR_IN_SEC = 2;
   localparam int RAIR_IN_ALM = 3;
   localparam int RAIR_SEC_LSB = RAIR_IN_SEC * RAIR_FIELD_W;
   localparam int RAIR_ALM_LSB = RAIR_IN_ALM * RAIR_FIELD_W;

   // ************************************************************
   // Field codes
   // ************************************************************
   typedef enum logic [1:0] {
      RAIR_EDGE_OFF,
      RAIR_EDGE_RISE,
      RAIR_EDGE_FALL,
      RAIR_EDGE_BOTH
   } rair_edge_t;

   typedef enum logic [1:0] {
      RAIR_SRC_PIN,
      RAIR_SRC_ALT,
      RAIR_SRC_OR,
      RAIR_SRC_AND
   } rair_src_t;
endpackage

// ---- rair_fast_input.sv ----
/*
 One fast interrupt input: source selection and edge detection.
 Assumes pin is already synchronised and alt comes from logic on the same clock.
*/
`timescale 1ns/1ns
module rair_fast_input
   import rair_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic pin,
   input wire logic alt,
   input wire logic [1:0] edge_code,
   input wire logic [1:0] src_code,
   output logic event_pulse
);
   typedef struct packed {
      logic prev;
   } rair_fin_state_t;

   rair_fin_state_t st_ff;
   rair_fin_state_t nxt_st;
   logic sel;

   always_comb begin
      nxt_st = st_ff;
      case (rair_src_t'(src_code))
         RAIR_SRC_PIN: sel = pin;
         RAIR_SRC_ALT: sel = alt;
         RAIR_SRC_OR: sel = pin | alt;
         RAIR_SRC_AND: sel = pin & alt;
         default: sel = pin;
      endcase
      case (rair_edge_t'(edge_code))
         RAIR_EDGE_OFF: event_pulse = 1'b0;
         RAIR_EDGE_RISE: event_pulse = sel & ~st_ff.prev;
         RAIR_EDGE_FALL: event_pulse = ~sel & st_ff.prev;
         RAIR_EDGE_BOTH: event_pulse = sel ^ st_ff.prev;
         default: event_pulse = 1'b0;
      endcase
      nxt_st.prev = sel;
      if (rst) begin
         nxt_st.prev = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      st_ff <= nxt_st;
   end
endmodule

// ---- rair_top_chk.sv ----
/*
 Port checker for rair_top, bound to it.
 Assumes REF_CLK and a synchronous active-high RST.
*/
`timescale 1ns/1ns
module rair_chk
   import rair_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic ALARM_IRQ_ENABLE_BIT,
   input wire logic SECOND_TICK_IN,
   input wire logic [15:0] ADDR,
   input wire logic WR_EN,
   input wire logic RD_EN,
   input wire logic [15:0] RDATA,
   input wire logic SECOND_TICK_REQUEST_LINE,
   input wire logic ALARM_REQUEST_LINE,
   input wire logic SECOND_TICK_IRQ,
   input wire logic ALARM_IRQ
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);
   wire wr_alm = WR_EN && ADDR == RAIR_ADDR_ALM_IC;
   wire wr_sec = WR_EN && ADDR == RAIR_ADDR_SEC_IC;
   wire ic_rd = RD_EN && (ADDR == RAIR_ADDR_SEC_IC || ADDR == RAIR_ADDR_ALM_IC);
   wire mapped = ADDR inside {RAIR_ADDR_ALARM_LOW, RAIR_ADDR_ALARM_HIGH, RAIR_ADDR_EDGE_SEL,
      RAIR_ADDR_SRC_SEL, RAIR_ADDR_SEC_IC, RAIR_ADDR_ALM_IC};
   a_reset_clears_out: assert property (disable iff (1'b0) RST |=> RDATA == 16'h0000 && !ALARM_IRQ
      && !SECOND_TICK_IRQ && !ALARM_REQUEST_LINE) else $error("outputs not cleared");
   a_sec_line_copy: assert property (!$past(RST) |-> SECOND_TICK_REQUEST_LINE == $past(SECOND_TICK_IN))
      else $error("second line wrong");
   a_alarm_needs_en: assert property (ALARM_REQUEST_LINE |-> $past(ALARM_IRQ_ENABLE_BIT))
      else $error("alarm line without enable");
   a_rdata_hold: assert property (!$past(RD_EN) && !$past(RST) |-> $stable(RDATA))
      else $error("read data moved");
   a_unmapped_read: assert property (RD_EN && !mapped |=> RDATA == 16'h0000)
      else $error("unmapped read not zero");
   a_alarm_irq_sticky: assert property (ALARM_IRQ && !wr_alm && !$past(wr_alm) |=> ALARM_IRQ)
      else $error("alarm irq dropped");
   a_sec_irq_sticky: assert property (SECOND_TICK_IRQ && !wr_sec && !$past(wr_sec) |=> SECOND_TICK_IRQ)
      else $error("second irq dropped");
   a_ctrl_upper_zero: assert property (ic_rd |=> RDATA[15:8] == 8'h00)
      else $error("control upper bits set");
   cover property ($rose(ALARM_IRQ));
   cover property ($rose(SECOND_TICK_IRQ));
   cover property (RD_EN && !mapped);
endmodule
bind rair_top rair_chk u_chk (.REF_CLK, .RST, .ALARM_IRQ_ENABLE_BIT, .SECOND_TICK_IN, .ADDR, .WR_EN,
   .RD_EN, .RDATA, .SECOND_TICK_REQUEST_LINE, .ALARM_REQUEST_LINE, .SECOND_TICK_IRQ, .ALARM_IRQ);

// ---- tb_rtc_alarm_interrupt_routing.sv ----
/*
 Register and event tests for rair_top.
 Assumes inputs change on the falling edge of a 100 MHz clock.
*/
`timescale 1ns/1ns
module tb_rtc_alarm_interrupt_routing
   import rair_pkg::*;
;
   logic ref_clk = 1'b0, rst = 1'b1, en = 1'b0, sec_in = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
   logic [15:0] cnt_high = 16'h0000, cnt_low = 16'h0000, addr = 16'h0000, wdata = 16'h0000, rdata;
   logic [1:0] firq_pin = 2'b00;
   logic sec_line, alm_line, sec_irq, alm_irq;
   int fail_count = 0, n_compared = 0;
   rair_top u_dut (.REF_CLK(ref_clk), .RST(rst), .CNT_HIGH(cnt_high), .CNT_LOW(cnt_low),
      .ALARM_IRQ_ENABLE_BIT(en), .SECOND_TICK_IN(sec_in), .FIRQ_PIN(firq_pin), .ADDR(addr),
      .WR_EN(wr_en), .WDATA(wdata), .RD_EN(rd_en), .RDATA(rdata), .SECOND_TICK_REQUEST_LINE(sec_line),
      .ALARM_REQUEST_LINE(alm_line), .SECOND_TICK_IRQ(sec_irq), .ALARM_IRQ(alm_irq));
   initial forever #5 ref_clk = ~ref_clk;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge ref_clk);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      @(negedge ref_clk);
      wr_en = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      @(negedge ref_clk);
      addr = a;
      rd_en = 1'b1;
      @(negedge ref_clk);
      rd_en = 1'b0;
      check(rdata, exp);
   endtask
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      fail_count++;
      finish_test();
   end
   initial begin
      cyc(6);
      rst = 1'b0;
      rd(RAIR_ADDR_SRC_SEL, 16'h0000);
      rd(RAIR_ADDR_ALM_IC, 16'h0000);
      rd(16'hEC16, 16'h0000);
      wr(RAIR_ADDR_ALARM_LOW, 16'h3C5A);
      wr(RAIR_ADDR_ALARM_HIGH, 16'hA1B2);
      wr(RAIR_ADDR_EDGE_SEL, 16'hE4D7);
      wr(RAIR_ADDR_SEC_IC, 16'hFFFF);
      rd(RAIR_ADDR_EDGE_SEL, 16'hE4D7);
      rd(RAIR_ADDR_SEC_IC, 16'h00FF);
      rst = 1'b1;
      cyc(2);
      rst = 1'b0;
      rd(RAIR_ADDR_ALARM_LOW, 16'h3C5A);
      rd(RAIR_ADDR_ALARM_HIGH, 16'hA1B2);
      rd(RAIR_ADDR_EDGE_SEL, 16'h0000);
      wr(RAIR_ADDR_EDGE_SEL, 16'h0050);
      wr(RAIR_ADDR_SRC_SEL, 16'h0050);
      wr(RAIR_ADDR_SEC_IC, 16'h0040);
      wr(RAIR_ADDR_ALM_IC, 16'h0040);
      cnt_high = 16'hA1B2;
      cnt_low = 16'h3C5A;
      cyc(3);
      check(16'(alm_line), 16'h0000);
      cnt_high = 16'h3C5A;
      cnt_low = 16'hA1B2;
      en = 1'b1;
      cyc(3);
      check(16'(alm_line), 16'h0000);
      cnt_high = 16'hA1B2;
      cnt_low = 16'h3C5A;
      cyc(1);
      check(16'(alm_line), 16'h0001);
      cyc(1);
      check(16'(alm_irq), 16'h0001);
      rd(RAIR_ADDR_ALM_IC, 16'h00C0);
      wr(RAIR_ADDR_ALM_IC, 16'h0040);
      cyc(3);
      check(16'(alm_irq), 16'h0000);
      cnt_low = 16'h0000;
      sec_in = 1'b1;
      cyc(1);
      sec_in = 1'b0;
      check(16'(sec_line), 16'h0001);
      cyc(1);
      check(16'(sec_irq), 16'h0001);
      rd(RAIR_ADDR_SEC_IC, 16'h00C0);
      for (int i = 0; i < 4; i++) begin
         wr(RAIR_ADDR_SRC_SEL, 16'(i) << 6);
         wr(RAIR_ADDR_ALM_IC, 16'h0040);
         firq_pin = 2'b10;
         cyc(6);
         check(16'(alm_irq), 16'(i % 2 == 0));
         firq_pin = 2'b00;
         cyc(6);
      end
      wr(RAIR_ADDR_SRC_SEL, 16'h0000);
      for (int k = 0; k < 4; k++) begin
         wr(RAIR_ADDR_EDGE_SEL, 16'(k) * 16'h0050);
         wr(RAIR_ADDR_SEC_IC, 16'h0040);
         wr(RAIR_ADDR_ALM_IC, 16'h0040);
         firq_pin = 2'b11;
         cyc(6);
         check(16'({sec_irq, alm_irq}), (k % 2 == 1) ? 16'h0003 : 16'h0000);
         wr(RAIR_ADDR_SEC_IC, 16'h0040);
         wr(RAIR_ADDR_ALM_IC, 16'h0040);
         firq_pin = 2'b00;
         cyc(6);
         check(16'({sec_irq, alm_irq}), (k >= 2) ? 16'h0003 : 16'h0000);
      end
      wr(RAIR_ADDR_EDGE_SEL, 16'h0050);
      wr(RAIR_ADDR_ALM_IC, 16'h0040);
      firq_pin = 2'b10;
      cyc(1);
      wr(RAIR_ADDR_ALM_IC, 16'h0040);
      check(16'(alm_irq), 16'h0001);
      rd(RAIR_ADDR_ALM_IC, 16'h00C0);
      firq_pin = 2'b00;
      wr(16'hEC13, 16'h0000);
      rd(RAIR_ADDR_ALARM_LOW, 16'h3C5A);
      finish_test();
   end
endmodule
